/* timer_pkg.sv */
package timer_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] OFF_GATE_CONTROL  = 8'h04;
  localparam logic [7:0] OFF_COUNT         = 8'h08;
  localparam logic [7:0] OFF_INT_STATUS    = 8'h0c;
  localparam logic [7:0] OFF_INT_MASK      = 8'h10;

  // timer_control field positions
  localparam int CS_HI   = 7;
  localparam int CS_LO   = 6;
  localparam int PS_HI   = 5;
  localparam int PS_LO   = 4;
  localparam int OSC_BIT = 3;
  localparam int SYN_BIT = 2;
  localparam int ON_BIT  = 0;

  // gate_control field positions
  localparam int GE_BIT  = 7;
  localparam int POL_BIT = 6;
  localparam int TM_BIT  = 5;
  localparam int SPM_BIT = 4;
  localparam int GO_BIT  = 3;
  localparam int GV_BIT  = 2;

  // interrupt status and mask bit positions
  localparam int INT_GATE = 0;
  localparam int INT_OVF  = 1;

  // clock source select encodings
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYS   = 2'h1;
  localparam logic [1:0] CS_EXT   = 2'h2;
  localparam logic [1:0] CS_CAP   = 2'h3;

  // instruction clock is the system clock divided by four
  localparam int         INSTR_DIV  = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

  // reset values and the count maximum
  localparam logic [7:0]  CTL_RESET   = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0]  INT_RESET   = 2'h0;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;

  // bus phase of the register slave
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WR   = 2'b01,
    PH_RD1  = 2'b10,
    PH_RD2  = 2'b11
  } bus_ph_t;

endpackage

/* sync2.sv */
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // first stage feeds only the second stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    if (rst) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_r <= st_nxt;
  end

  assign q = st_r.s2;

endmodule // sync2

/* timer1_clock_select_and_gate_pulse.sv */
`timescale 1ns/1ps
module timer1_clock_select_and_gate_pulse (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        por_reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        ext_clock_pin,
  input  wire logic        crystal_in_pin,
  input  wire logic        cap_sense_osc,
  input  wire logic        gate_pin,
  output logic             osc_enable,
  output logic             irq
);

  typedef struct packed {
    // timer_control fields
    logic [1:0]               cs;
    logic [1:0]               ps;
    logic                     osc_en;
    logic                     sync_dis;
    logic                     on;
    // gate_control fields
    logic                     ge;
    logic                     pol;
    logic                     tm;
    logic                     spm;
    logic                     go;
    // counting state
    logic [15:0]              count;
    logic [1:0]               q;
    logic [2:0]               pre;
    logic                     ext_pend;
    logic                     ext_d;
    logic                     xtal_d;
    logic                     cap_d;
    logic                     g_d;
    logic                     tff;
    logic                     gin_d;
    logic                     sp_act;
    logic                     gval_d;
    // interrupts
    logic [1:0]               st;
    logic [1:0]               mask;
    // bus slave
    timer_pkg::bus_ph_t       ph;
    logic [7:0]               addr;
    logic [31:0]              rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [3:0] pins_sync;
  logic       ext_s;
  logic       xtal_s;
  logic       cap_s;
  logic       gate_s;

  // every pin passes two flops before the block looks at it
  sync2 #(
    .W (4)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       ({gate_pin, cap_sense_osc, crystal_in_pin, ext_clock_pin}),
    .q       (pins_sync)
  );

  assign ext_s  = pins_sync[0];
  assign xtal_s = pins_sync[1];
  assign cap_s  = pins_sync[2];
  assign gate_s = pins_sync[3];

  // byte offset of a bus address, shared by read and write decode
  function automatic logic [7:0] reg_off(input logic [31:0] a);
    reg_off = {a[7:2], 2'b00};
  endfunction

  // prescale mask: the divider ticks once all masked bits are set
  function automatic logic [2:0] ps_mask(input logic [1:0] ps);
    case (ps)
      2'h0:    ps_mask = 3'h0;
      2'h1:    ps_mask = 3'h1;
      2'h2:    ps_mask = 3'h3;
      default: ps_mask = 3'h7;
    endcase
  endfunction

  // gate value as software sees it, from stored state and the synced pin
  logic gin;
  logic gsel;
  logic gval;

  always_comb begin
    gin  = s_r.pol ? gate_s : ~gate_s;
    gsel = s_r.tm ? s_r.tff : gin;
    gval = s_r.spm ? (s_r.sp_act & gsel) : gsel;
  end

  // register read data
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_r.addr)
      timer_pkg::OFF_TIMER_CONTROL: begin
        rd_val[7:0] = {s_r.cs, s_r.ps, s_r.osc_en, s_r.sync_dis, 1'b0, s_r.on};
      end
      timer_pkg::OFF_GATE_CONTROL: begin
        rd_val[7:0] = {s_r.ge, s_r.pol, s_r.tm, s_r.spm, s_r.go, gval, 2'b00};
      end
      timer_pkg::OFF_COUNT: begin
        rd_val[15:0] = s_r.count;
      end
      timer_pkg::OFF_INT_STATUS: begin
        rd_val[1:0] = s_r.st;
      end
      timer_pkg::OFF_INT_MASK: begin
        rd_val[1:0] = s_r.mask;
      end
      default: begin
        rd_val = 32'h0000_0000; // unmapped reads as zero
      end
    endcase
  end

  // next-state logic: bus, clock selection, prescaler, gate, counter
  logic        accept;
  logic        wr_now;
  logic        src_tick;
  logic        inc_tick;
  logic        ext_rise;
  logic        xtal_rise;
  logic        cap_rise;
  logic        gin_rise;
  logic        g_rise;
  logic        gval_fall;
  logic        cnt_en;
  logic        cnt_wr;
  logic [7:0]  wd;

  always_comb begin
    s_nxt     = s_r;
    accept    = hsel & hready & htrans[1];
    wr_now    = (s_r.ph == timer_pkg::PH_WR);
    wd        = hwdata[7:0];
    cnt_wr    = 1'b0;
    src_tick  = 1'b0;
    inc_tick  = 1'b0;
    ext_rise  = ext_s & ~s_r.ext_d;
    xtal_rise = xtal_s & ~s_r.xtal_d;
    cap_rise  = cap_s & ~s_r.cap_d;
    gin_rise  = gin & ~s_r.gin_d;
    g_rise    = gsel & ~s_r.g_d;
    gval_fall = s_r.gval_d & ~gval;

    // bus phase: reads take one wait state so the data leave a flop
    case (s_r.ph)
      timer_pkg::PH_RD1: begin
        s_nxt.rdata = rd_val;
        s_nxt.ph    = timer_pkg::PH_RD2;
        if (s_r.addr == timer_pkg::OFF_INT_STATUS) begin
          s_nxt.st = timer_pkg::INT_RESET; // read clears; events below win
        end
      end
      default: begin
        s_nxt.ph = timer_pkg::PH_IDLE;
        if (accept) begin
          s_nxt.addr = reg_off(haddr);
          s_nxt.ph   = hwrite ? timer_pkg::PH_WR : timer_pkg::PH_RD1;
        end
      end
    endcase

    // register writes commit in the data phase
    if (wr_now) begin
      case (s_r.addr)
        timer_pkg::OFF_TIMER_CONTROL: begin
          s_nxt.cs       = wd[timer_pkg::CS_HI:timer_pkg::CS_LO];
          s_nxt.ps       = wd[timer_pkg::PS_HI:timer_pkg::PS_LO];
          s_nxt.osc_en   = wd[timer_pkg::OSC_BIT];
          s_nxt.sync_dis = wd[timer_pkg::SYN_BIT];
          s_nxt.on       = wd[timer_pkg::ON_BIT];
        end
        timer_pkg::OFF_GATE_CONTROL: begin
          s_nxt.ge  = wd[timer_pkg::GE_BIT];
          s_nxt.pol = wd[timer_pkg::POL_BIT];
          s_nxt.tm  = wd[timer_pkg::TM_BIT];
          s_nxt.spm = wd[timer_pkg::SPM_BIT];
          s_nxt.go  = wd[timer_pkg::GO_BIT];
        end
        timer_pkg::OFF_COUNT: begin
          s_nxt.count = hwdata[15:0];
          cnt_wr      = 1'b1;
        end
        timer_pkg::OFF_INT_MASK: begin
          s_nxt.mask = hwdata[1:0];
        end
        default: begin
          s_nxt.addr = s_r.addr; // writes to unmapped offsets are dropped
        end
      endcase
    end

    // instruction clock phase counter runs free
    s_nxt.q      = s_r.q + 2'h1;
    s_nxt.ext_d  = ext_s;
    s_nxt.xtal_d = xtal_s;
    s_nxt.cap_d  = cap_s;

    // source selection
    case (s_r.cs)
      timer_pkg::CS_INSTR: begin
        src_tick = (s_r.q == timer_pkg::INSTR_LAST);
      end
      timer_pkg::CS_SYS: begin
        src_tick = 1'b1;
      end
      timer_pkg::CS_EXT: begin
        if (s_r.osc_en) begin
          src_tick = xtal_rise;
        end else if (s_r.sync_dis) begin
          src_tick = ext_rise;
        end else begin
          // synchronised edges are held until the instruction boundary
          if (ext_rise) begin
            s_nxt.ext_pend = 1'b1;
          end
          if ((s_r.ext_pend | ext_rise) && s_r.q == timer_pkg::INSTR_LAST) begin
            src_tick       = 1'b1;
            s_nxt.ext_pend = 1'b0;
          end
        end
      end
      timer_pkg::CS_CAP: begin
        src_tick = cap_rise;
      end
      default: begin
        src_tick = 1'b0;
      end
    endcase
    if (s_r.cs != timer_pkg::CS_EXT || s_r.osc_en || s_r.sync_dis) begin
      s_nxt.ext_pend = 1'b0;
    end

    // prescaler: only the divider restarts on a new ratio, never the count
    if (src_tick && s_r.on) begin
      s_nxt.pre = s_r.pre + 3'h1;
      inc_tick  = ((s_r.pre & ps_mask(s_r.ps)) == ps_mask(s_r.ps));
      if (inc_tick) begin
        s_nxt.pre = 3'h0;
      end
    end
    if (s_nxt.ps != s_r.ps) begin
      s_nxt.pre = 3'h0;
    end

    // toggle flop: cleared while toggle mode is off or the timer is off
    s_nxt.gin_d = gin;
    if (!s_r.tm || !s_r.on) begin
      s_nxt.tff = 1'b0;
    end else if (gin_rise) begin
      s_nxt.tff = ~s_r.tff;
    end

    // single pulse: armed by go/done, opens on the next gate rise
    s_nxt.g_d = gsel;
    if (!s_r.spm || !s_r.go) begin
      s_nxt.sp_act = 1'b0;
    end else if (g_rise) begin
      s_nxt.sp_act = 1'b1;
    end

    // trailing edge of the gate value ends the pulse
    s_nxt.gval_d = gval;
    if (gval_fall) begin
      if (s_r.spm && !(wr_now && s_r.addr == timer_pkg::OFF_GATE_CONTROL)) begin
        s_nxt.go = 1'b0;
      end
      s_nxt.st[timer_pkg::INT_GATE] = 1'b1;
    end

    // counter: a software write takes precedence over an increment
    cnt_en = s_r.on & (~s_r.ge | gval);
    if (cnt_en && inc_tick && !cnt_wr) begin
      s_nxt.count = s_r.count + 16'h0001;
      if (s_r.count == timer_pkg::COUNT_MAX) begin
        s_nxt.st[timer_pkg::INT_OVF] = 1'b1;
      end
    end

    // reset: control bits survive every reset but power-on
    if (rst) begin
      s_nxt       = '0;
      s_nxt.count = timer_pkg::COUNT_RESET;
      s_nxt.st    = timer_pkg::INT_RESET;
      s_nxt.mask  = timer_pkg::INT_RESET;
      s_nxt.ph    = timer_pkg::PH_IDLE;
      // edge detectors track their inputs so a kept setup sees no false edge
      s_nxt.ext_d  = ext_s;
      s_nxt.xtal_d = xtal_s;
      s_nxt.cap_d  = cap_s;
      s_nxt.gin_d  = gin;
      s_nxt.g_d    = gsel;
      s_nxt.gval_d = gval;
      if (!por_reset) begin
        s_nxt.cs       = s_r.cs;
        s_nxt.ps       = s_r.ps;
        s_nxt.osc_en   = s_r.osc_en;
        s_nxt.sync_dis = s_r.sync_dis;
        s_nxt.on       = s_r.on;
        s_nxt.ge       = s_r.ge;
        s_nxt.pol      = s_r.pol;
        s_nxt.tm       = s_r.tm;
        s_nxt.spm      = s_r.spm;
        s_nxt.go       = s_r.go;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    s_r <= s_nxt;
  end

  // outputs
  assign hreadyout  = (s_r.ph != timer_pkg::PH_RD1);
  assign hresp      = 1'b0;
  assign hrdata     = s_r.rdata;
  assign osc_enable = s_r.osc_en;
  assign irq        = |(s_r.st & s_r.mask);

endmodule // timer1_clock_select_and_gate_pulse

/* timer_checker.sv */
`timescale 1ns/1ps
module timer_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        por_reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        osc_enable,
  input wire logic        irq
);
  // a transfer is taken when selected, ready and non-idle
  wire take = hsel & hready & htrans[1];
  wire ctl  = haddr[7:2] == 6'h00;

  default clocking @(posedge sys_clk); endclocking

  a_write_no_wait: assert property (disable iff (rst) take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_read_one_wait: assert property (disable iff (rst)
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_osc_follows_write: assert property (disable iff (rst)
    take && hwrite && ctl |=> ##1 osc_enable == $past(hwdata[timer_pkg::OSC_BIT]))
    else $error("oscillator enable not written");
  a_osc_por_clear: assert property (rst && por_reset |=> !osc_enable)
    else $error("oscillator enable kept over power-on reset");
  a_osc_kept_reset: assert property (rst && !por_reset |=> $stable(osc_enable))
    else $error("oscillator enable lost over warm reset");
  a_bit1_reads_zero: assert property (disable iff (rst)
    take && !hwrite && ctl |-> ##2 (hrdata[1] == 1'b0 && hrdata[31:8] == 24'h0))
    else $error("control read shows unimplemented bits");
  a_irq_reset_low: assert property (rst |=> !irq)
    else $error("interrupt high after reset");
  a_osc_no_spurious: assert property (disable iff (rst)
    !(take && hwrite && ctl) && !rst |=> ##1 $stable(osc_enable))
    else $error("oscillator enable moved without a write");
endmodule // timer_checker

bind timer1_clock_select_and_gate_pulse timer_checker timer_checker_i (
  .sys_clk(sys_clk), .rst(rst), .por_reset(por_reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .osc_enable(osc_enable), .irq(irq));

/* clock_source_model.sv */
`timescale 1ns/1ps
module clock_source_model (
  input  wire logic       run,
  input  wire logic       xtal_on,
  input  wire logic [1:0] pick,
  output logic            ext_clock_pin,
  output logic            crystal_in_pin,
  output logic            cap_sense_osc
);
  logic osc_r = 1'b0;

  // 40 ns source; stands low between bursts, like a gated oscillator
  always #20 osc_r = run ? ~osc_r : 1'b0;

  // only the picked source moves, the others idle low
  assign ext_clock_pin  = osc_r & (pick == 2'h0);
  // the crystal only swings while the block powers its oscillator
  assign crystal_in_pin = osc_r & xtal_on & (pick == 2'h1);
  assign cap_sense_osc  = osc_r & (pick == 2'h2);
endmodule // clock_source_model

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        por_reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        gate_pin = 1'b0;
  logic        run = 1'b0;
  logic [1:0]  pick = 2'h3;
  logic        hready, hresp, osc_enable, irq, ext_pin, xtal_pin, cap_pin;
  logic [31:0] hrdata, q, e;
  logic [31:0] seed = 32'h3344_2006;
  logic [7:0]  ext_ctl [4] = '{8'h81, 8'h85, 8'h89, 8'hc1};
  int          bad_count = 0;
  int          samples_checked = 0;

  always #2.5 sys_clk = ~sys_clk;

  timer1_clock_select_and_gate_pulse timer1_clock_select_and_gate_pulse_i (
    .sys_clk(sys_clk), .rst(rst), .por_reset(por_reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .ext_clock_pin(ext_pin),
    .crystal_in_pin(xtal_pin), .cap_sense_osc(cap_pin), .gate_pin(gate_pin),
    .osc_enable(osc_enable), .irq(irq));

  clock_source_model clock_source_model_i (.run(run), .xtal_on(osc_enable), .pick(pick),
    .ext_clock_pin(ext_pin), .crystal_in_pin(xtal_pin), .cap_sense_osc(cap_pin));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // bounded wait for ready; a stuck bus ends the run
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      end_sim;
    end
  endtask

  // one single word transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask

  task automatic do_reset(input logic por);
    rst       <= 1'b1;
    por_reset <= por;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  // one gate pulse: high for hi cycles, then low for lo cycles
  task automatic pulse(input int hi, input int lo);
    gate_pin <= 1'b1;
    repeat (hi) @(posedge sys_clk);
    gate_pin <= 1'b0;
    repeat (lo) @(posedge sys_clk);
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // start and stop of a run blur the count by a few ticks
  function automatic logic [31:0] near(input logic [31:0] s, input logic [31:0] x);
    return (s + 3 >= x && s <= x + 3) ? x : s;
  endfunction

  // clear the count, run 256 cycles with the far side active, stop, read the count
  task automatic run_for(input logic [7:0] c);
    bus(1'b1, timer_pkg::OFF_COUNT, 32'h0);
    bus(1'b1, timer_pkg::OFF_TIMER_CONTROL, {24'h0, c});
    run <= 1'b1;
    repeat (256) @(posedge sys_clk);
    run <= 1'b0;
    bus(1'b1, timer_pkg::OFF_TIMER_CONTROL, {24'h0, c & 8'hfe});
    bus(1'b0, timer_pkg::OFF_COUNT, 32'h0);
  endtask

  initial begin
    do_reset(1'b1);
    check("irq", irq, 1'b0);
    bus(1'b0, timer_pkg::OFF_TIMER_CONTROL, 32'h0);
    check("ctl reset", q, 32'h0);
    bus(1'b0, 8'h40, 32'hffff_ffff);
    check("unmapped", q, 32'h0);
    check("hresp", hresp, 1'b0);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      bus(1'b1, timer_pkg::OFF_TIMER_CONTROL, seed);
      bus(1'b0, timer_pkg::OFF_TIMER_CONTROL, 32'h0);
      check("ctl", q, {24'h0, seed[7:0] & 8'hfd});
      check("osc_enable", osc_enable, seed[3]);
    end
    do_reset(1'b0);
    bus(1'b0, timer_pkg::OFF_TIMER_CONTROL, 32'h0);
    check("ctl kept", q, {24'h0, seed[7:0] & 8'hfd});
    do_reset(1'b1);
    bus(1'b0, timer_pkg::OFF_TIMER_CONTROL, 32'h0);
    check("ctl cleared", q, 32'h0);
    // internal sources at every prescale
    for (int c = 0; c < 2; c++)
      for (int p = 0; p < 4; p++) begin
        e = 32'(256 / ((c == 0 ? 4 : 1) << p));
        run_for({c[1:0], p[1:0], 4'h1});
        check("count", near(q, e), e);
      end
    // prescale change mid-run: 67 counts at 1:1, then 67 ticks at 1:8
    bus(1'b1, timer_pkg::OFF_COUNT, 32'h0);
    bus(1'b1, timer_pkg::OFF_TIMER_CONTROL, 32'h41);
    repeat (64) @(posedge sys_clk);
    bus(1'b1, timer_pkg::OFF_TIMER_CONTROL, 32'h71);
    repeat (64) @(posedge sys_clk);
    bus(1'b1, timer_pkg::OFF_TIMER_CONTROL, 32'h70);
    bus(1'b0, timer_pkg::OFF_COUNT, 32'h0);
    check("ps change", near(q, 75), 75);
    // a stopped timer holds a written count
    bus(1'b1, timer_pkg::OFF_COUNT, 32'h1234);
    repeat (40) @(posedge sys_clk);
    bus(1'b0, timer_pkg::OFF_COUNT, 32'h0);
    check("stopped", q, 32'h1234);
    // rollover raises the overflow status and, unmasked, the interrupt
    bus(1'b1, timer_pkg::OFF_INT_MASK, 32'h2);
    bus(1'b1, timer_pkg::OFF_COUNT, 32'hfff0);
    bus(1'b1, timer_pkg::OFF_TIMER_CONTROL, 32'h41);
    repeat (30) @(posedge sys_clk);
    check("irq overflow", irq, 1'b1);
    bus(1'b1, timer_pkg::OFF_TIMER_CONTROL, 32'h40);
    bus(1'b0, timer_pkg::OFF_INT_STATUS, 32'h0);
    check("status", q, 32'h2);
    check("irq cleared", irq, 1'b0);
    bus(1'b1, timer_pkg::OFF_INT_MASK, 32'h0);
    // pin synced, pin raw, crystal, capacitive source: 32 edges each
    for (int k = 0; k < 4; k++) begin
      pick <= (k == 0) ? 2'h0 : 2'(k - 1);
      run_for(ext_ctl[k]);
      check("ext count", near(q, 32), 32);
    end
    pick <= 2'h3;
    // toggle mode: one full gate period, rise to rise, is counted
    bus(1'b1, timer_pkg::OFF_COUNT, 32'h0);
    bus(1'b1, timer_pkg::OFF_GATE_CONTROL, 32'he0);
    bus(1'b1, timer_pkg::OFF_TIMER_CONTROL, 32'h41);
    pulse(10, 30);
    pulse(10, 30);
    bus(1'b0, timer_pkg::OFF_COUNT, 32'h0);
    check("toggle count", near(q, 40), 40);
    pulse(10, 10);
    bus(1'b0, timer_pkg::OFF_GATE_CONTROL, 32'h0);
    check("gate value", q, 32'he4);
    bus(1'b1, timer_pkg::OFF_TIMER_CONTROL, 32'h40);
    bus(1'b0, timer_pkg::OFF_GATE_CONTROL, 32'h0);
    check("flop cleared", q, 32'he0);
    // single pulse: enable first, then arm go/done, then start the timer
    bus(1'b1, timer_pkg::OFF_COUNT, 32'h0);
    bus(1'b1, timer_pkg::OFF_GATE_CONTROL, 32'hd0);
    bus(1'b1, timer_pkg::OFF_GATE_CONTROL, 32'hd8);
    bus(1'b1, timer_pkg::OFF_TIMER_CONTROL, 32'h41);
    // second pulse is not armed and must not count
    for (int i = 0; i < 2; i++) begin
      pulse(40, 10);
      bus(1'b0, timer_pkg::OFF_COUNT, 32'h0);
      check("pulse count", near(q, 40), 40);
      bus(1'b0, timer_pkg::OFF_GATE_CONTROL, 32'h0);
      check("go_done", q[timer_pkg::GO_BIT], 1'b0);
      check("irq masked", irq, 1'b0);
    end
    bus(1'b1, timer_pkg::OFF_INT_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    check("irq", irq, 1'b1);
    bus(1'b0, timer_pkg::OFF_INT_STATUS, 32'h0);
    check("gate flag", q, 32'h1);
    check("irq cleared", irq, 1'b0);
    end_sim;
  end
endmodule // testbench
